// [amd_pkg.sv]
`default_nettype none
package amd_pkg;
    // ************************************************************
    // Register map (word offsets are byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACT_THR = 8'h04;
    localparam logic [7:0] ADDR_ACT_TIME = 8'h08;
    localparam logic [7:0] ADDR_INACT_THR = 8'h0c;
    localparam logic [7:0] ADDR_INACT_TIME = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_SAMPLE = 8'h18;
    localparam logic [31:0] UNMAPPED_DATA = 32'hdeadbeef;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RANGE_LSB = 2;
    localparam int CTRL_ODR_LSB = 4;
    localparam int CTRL_HALF_BANDWIDTH_SELECT = 7;
    localparam int CTRL_NOISE_LSB = 8;
    localparam int CTRL_ACT_EN = 10;
    localparam int CTRL_INACT_EN = 11;
    localparam int CTRL_ACT_REF = 12;
    localparam int CTRL_INACT_REF = 13;
    localparam int CTRL_LINK = 14;
    localparam int CTRL_ACT_IRQ_EN = 15;
    localparam int CTRL_INACT_IRQ_EN = 16;
    localparam logic [16:0] CTRL_RESET = 17'h00000;
    // Status bit positions
    localparam int ST_ACT = 0;
    localparam int ST_INACT = 1;
    localparam int ST_AWAKE = 2;
    // ************************************************************
    // Modes
    // ************************************************************
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_MEASURE = 2'h2;
    localparam logic [1:0] MODE_WAKEUP = 2'h1;
    localparam int SAMPLE_BITS = 12;
    // ************************************************************
    // Sample pacing: 12.5 Hz..400 Hz and wake-up about 6 Hz
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int ODR_MHZ_12P5 = 12_500;
    localparam int ODR_MHZ_400 = 400_000;
    localparam int ODR_MHZ_WAKE = 6_000;
    localparam int DIV_400 = (CLK_HZ / ODR_MHZ_400) * 1000;
    localparam int DIV_WAKE = (CLK_HZ / ODR_MHZ_WAKE) * 1000;
    localparam int DIV_12P5 = (CLK_HZ / ODR_MHZ_12P5) * 1000;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_MEASURING = 3'b010,
        ST_WAKING = 3'b100
    } amd_state_t;

    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } amd_sample_t;

    typedef struct packed {
        logic [1:0] noise_mode;
        logic [1:0] range;
        logic half_bandwidth_select;
    } amd_afe_cfg_t;
endpackage : amd_pkg
`default_nettype wire

// [amd_ctrl.sv]
`default_nettype none
module amd_ctrl #(
    // Divider speed-up for short simulations; zero keeps the exact data rates
    parameter int RATE_SHIFT = 0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire amd_pkg::amd_sample_t adc_sample_in,
    output logic adc_convert_out,
    output amd_pkg::amd_afe_cfg_t afe_cfg_out,
    output logic afe_power_out,
    output logic act_irq_out,
    output logic inact_irq_out,
    output logic awake_out
);
    import amd_pkg::*;

    amd_state_t state_q;
    logic [16:0] ctrl_q;
    logic [11:0] act_thr_q, inact_thr_q;
    logic [15:0] act_time_q, inact_time_q;
    logic [15:0] act_cnt_q, inact_cnt_q;
    logic [2:0] status_q;
    amd_sample_t sample_q, ref_q;
    logic [23:0] div_cnt_q;
    logic tick_q;
    logic ack_q;
    logic ref_pend_q;
    logic [2:0] odr_sel;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [11:0] mag(input logic signed [11:0] a,
                                        input logic signed [11:0] r, input logic use_ref);
        logic signed [12:0] d;
        d = use_ref ? (13'(a) - 13'(r)) : 13'(a);
        mag = d[12] ? 12'((-d) > 13'h0fff ? 13'h0fff : -d) : (d > 13'h0fff ? 12'hfff : 12'(d));
    endfunction

    function automatic logic [23:0] odr_div(input logic [2:0] sel);
        // Each step halves the rate from 400 Hz down to 12.5 Hz
        odr_div = 24'(DIV_400) << (3'h5 - (sel > 3'h5 ? 3'h5 : sel));
    endfunction

    // ************************************************************
    // Avalon-MM slave: one wait state, then answer
    // ************************************************************
    wire req = (avs_read_in | avs_write_in) & ~ack_q;
    wire wr_take = avs_write_in & ack_q;
    wire rd_take = avs_read_in & ack_q;
    // Clear at the edge that snapshots the status, so no event is lost between
    wire st_clr = req && avs_read_in && avs_address_in == ADDR_STATUS;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~req;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0;
        end else if (req && avs_read_in) begin
            if (avs_address_in == ADDR_CTRL) begin
                avs_readdata_out <= {15'h0, ctrl_q};
            end else if (avs_address_in == ADDR_ACT_THR) begin
                avs_readdata_out <= {20'h0, act_thr_q};
            end else if (avs_address_in == ADDR_ACT_TIME) begin
                avs_readdata_out <= {16'h0, act_time_q};
            end else if (avs_address_in == ADDR_INACT_THR) begin
                avs_readdata_out <= {20'h0, inact_thr_q};
            end else if (avs_address_in == ADDR_INACT_TIME) begin
                avs_readdata_out <= {16'h0, inact_time_q};
            end else if (avs_address_in == ADDR_STATUS) begin
                avs_readdata_out <= {29'h0, status_q};
            end else if (avs_address_in == ADDR_SAMPLE) begin
                avs_readdata_out <= {4'h0, sample_q.x[11:4], sample_q.y, sample_q.z[11:4]};
            end else begin
                avs_readdata_out <= UNMAPPED_DATA;
            end
        end
    end

    // Byte-lane writes for control, thresholds and times
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= CTRL_RESET;
            act_thr_q <= 12'h0;
            inact_thr_q <= 12'h0;
            act_time_q <= 16'h0;
            inact_time_q <= 16'h0;
        end else if (wr_take) begin
            if (avs_address_in == ADDR_CTRL) begin
                if (avs_byteenable_in[0]) ctrl_q[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1]) ctrl_q[15:8] <= avs_writedata_in[15:8];
                if (avs_byteenable_in[2]) ctrl_q[16] <= avs_writedata_in[16];
            end else if (avs_address_in == ADDR_ACT_THR) begin
                if (avs_byteenable_in[0]) act_thr_q[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1]) act_thr_q[11:8] <= avs_writedata_in[11:8];
            end else if (avs_address_in == ADDR_ACT_TIME) begin
                if (avs_byteenable_in[0]) act_time_q[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1]) act_time_q[15:8] <= avs_writedata_in[15:8];
            end else if (avs_address_in == ADDR_INACT_THR) begin
                if (avs_byteenable_in[0]) inact_thr_q[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1]) inact_thr_q[11:8] <= avs_writedata_in[11:8];
            end else if (avs_address_in == ADDR_INACT_TIME) begin
                if (avs_byteenable_in[0]) inact_time_q[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1]) inact_time_q[15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    // ************************************************************
    // Mode state machine
    // ************************************************************
    wire [1:0] mode_sel = ctrl_q[CTRL_MODE_LSB +: 2];
    wire link_en = ctrl_q[CTRL_LINK];
    wire act_en = ctrl_q[CTRL_ACT_EN];
    wire inact_en = ctrl_q[CTRL_INACT_EN];
    logic enter_meas;
    assign enter_meas = (state_q != ST_MEASURING) && (mode_sel == MODE_MEASURE);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_STANDBY;
        end else begin
            case (mode_sel)
                MODE_MEASURE: state_q <= ST_MEASURING;
                MODE_WAKEUP: state_q <= ST_WAKING;
                default: state_q <= ST_STANDBY;
            endcase
        end
    end

    // ************************************************************
    // Sample pacing divider
    // ************************************************************
    assign odr_sel = ctrl_q[CTRL_ODR_LSB +: 3];
    wire [23:0] div_top = ((state_q == ST_WAKING) ? 24'(DIV_WAKE) : odr_div(odr_sel))
                          >> RATE_SHIFT;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_q <= 24'h0;
            tick_q <= 1'b0;
        end else if (state_q == ST_STANDBY) begin
            div_cnt_q <= 24'h0;
            tick_q <= 1'b0;
        end else if (div_cnt_q >= div_top - 24'h1) begin
            div_cnt_q <= 24'h0;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 24'h1;
            tick_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adc_convert_out <= 1'b0;
            afe_power_out <= 1'b0;
            afe_cfg_out <= '0;
        end else begin
            adc_convert_out <= tick_q && state_q != ST_STANDBY;
            afe_power_out <= state_q != ST_STANDBY;
            afe_cfg_out.noise_mode <= ctrl_q[CTRL_NOISE_LSB +: 2];
            afe_cfg_out.range <= ctrl_q[CTRL_RANGE_LSB +: 2];
            afe_cfg_out.half_bandwidth_select <= ctrl_q[CTRL_HALF_BANDWIDTH_SELECT];
        end
    end

    // ************************************************************
    // Motion detection; sample arrives one cycle after the strobe
    // ************************************************************
    logic smp_v_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            smp_v_q <= 1'b0;
            sample_q <= '0;
        end else begin
            smp_v_q <= adc_convert_out && state_q != ST_STANDBY;
            if (adc_convert_out && state_q != ST_STANDBY) sample_q <= adc_sample_in;
        end
    end

    wire act_ref = ctrl_q[CTRL_ACT_REF];
    wire inact_ref = ctrl_q[CTRL_INACT_REF];
    // Any axis may trigger activity; inactivity needs every axis quiet
    wire act_hit = (mag(sample_q.x, ref_q.x, act_ref) > act_thr_q) |
                   (mag(sample_q.y, ref_q.y, act_ref) > act_thr_q) |
                   (mag(sample_q.z, ref_q.z, act_ref) > act_thr_q);
    wire quiet = (mag(sample_q.x, ref_q.x, inact_ref) <= inact_thr_q) &
                 (mag(sample_q.y, ref_q.y, inact_ref) <= inact_thr_q) &
                 (mag(sample_q.z, ref_q.z, inact_ref) <= inact_thr_q);
    wire awake = status_q[ST_AWAKE];
    // The sample that becomes the reference is not judged for activity against the old one
    wire act_live = act_en && (!link_en || !awake) && !(act_ref && ref_pend_q);
    wire inact_live = inact_en && (!link_en || awake);
    // Wake-up activity uses a single sample; inactivity and measurement activity honour the timers
    wire [15:0] act_need = (state_q == ST_WAKING || act_time_q == 16'h0) ? 16'h1 : act_time_q;
    wire [15:0] inact_need = (inact_time_q == 16'h0) ? 16'h1 : inact_time_q;
    wire act_fire = smp_v_q && act_live && act_hit && (act_cnt_q + 16'h1 >= act_need);
    wire inact_fire = smp_v_q && inact_live && quiet && (inact_cnt_q + 16'h1 >= inact_need);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            act_cnt_q <= 16'h0;
            inact_cnt_q <= 16'h0;
        end else if (enter_meas) begin
            act_cnt_q <= 16'h0;
            inact_cnt_q <= 16'h0;
        end else if (smp_v_q) begin
            act_cnt_q <= (act_hit && act_live && !act_fire) ? act_cnt_q + 16'h1 : 16'h0;
            inact_cnt_q <= (quiet && inact_live && !inact_fire) ? inact_cnt_q + 16'h1 : 16'h0;
        end
    end

    // On entry to measurement no sample exists yet, so with activity enabled the next one is taken
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_pend_q <= 1'b0;
        end else if (enter_meas && act_en) begin
            ref_pend_q <= 1'b1;
        end else if (smp_v_q) begin
            ref_pend_q <= 1'b0;
        end
    end

    // Activity events (inactivity events when linked) recapture the sample that caused them
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_q <= '0;
        end else if ((link_en && inact_fire) || (!link_en && act_fire)) begin
            ref_q <= sample_q;
        end else if (smp_v_q && ref_pend_q) begin
            ref_q <= sample_q;
        end
    end

    // Status: events set, reading the status clears ACT and INACT but not AWAKE; set wins
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_q <= 3'h0;
        end else begin
            status_q[ST_ACT] <= act_fire | (status_q[ST_ACT] & ~st_clr);
            status_q[ST_INACT] <= inact_fire | (status_q[ST_INACT] & ~st_clr);
            if (act_fire) status_q[ST_AWAKE] <= 1'b1;
            else if (inact_fire) status_q[ST_AWAKE] <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            act_irq_out <= 1'b0;
            inact_irq_out <= 1'b0;
            awake_out <= 1'b0;
        end else begin
            act_irq_out <= status_q[ST_ACT] & ctrl_q[CTRL_ACT_IRQ_EN];
            inact_irq_out <= status_q[ST_INACT] & ctrl_q[CTRL_INACT_IRQ_EN];
            awake_out <= status_q[ST_AWAKE];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_standby_quiet;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == ST_STANDBY) |=> !adc_convert_out[*2] ##0
        ((status_q[1:0] & ~$past(status_q[1:0])) == 2'h0);
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("sampling in standby");
    property p_power_off;
        @(posedge clk_in) disable iff (!nrst_in)
        (state_q == ST_STANDBY) |=> !afe_power_out;
    endproperty
    a_power_off: assert property (p_power_off) else $error("sensor powered in standby");
    property p_bw;
        @(posedge clk_in) disable iff (!nrst_in)
        1'b1 |=> afe_cfg_out.half_bandwidth_select ==
                 $past(ctrl_q[CTRL_HALF_BANDWIDTH_SELECT]);
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth select lost");
    sequence s_tick;
        tick_q ##1 adc_convert_out;
    endsequence
    property p_convert;
        @(posedge clk_in) disable iff (!nrst_in)
        tick_q && state_q != ST_STANDBY && mode_sel != MODE_STANDBY |-> s_tick;
    endproperty
    a_convert: assert property (p_convert) else $error("convert strobe missing");
    property p_act_flag;
        @(posedge clk_in) disable iff (!nrst_in)
        act_fire |=> status_q[ST_ACT] && status_q[ST_AWAKE];
    endproperty
    a_act_flag: assert property (p_act_flag) else $error("activity not flagged");
    property p_irq;
        @(posedge clk_in) disable iff (!nrst_in)
        act_fire && ctrl_q[CTRL_ACT_IRQ_EN] |=> ##1 act_irq_out || !$past(ctrl_q[CTRL_ACT_IRQ_EN], 1);
    endproperty
    a_irq: assert property (p_irq) else $error("activity irq missing");
    property p_asleep;
        @(posedge clk_in) disable iff (!nrst_in)
        inact_fire && !act_fire |=> !status_q[ST_AWAKE] ##1 !awake_out;
    endproperty
    a_asleep: assert property (p_asleep) else $error("awake after inactivity");
    property p_wake_single;
        @(posedge clk_in) disable iff (!nrst_in)
        smp_v_q && state_q == ST_WAKING && act_live && act_hit |-> act_fire;
    endproperty
    a_wake_single: assert property (p_wake_single) else $error("wake-up not single sample");
    property p_ref;
        @(posedge clk_in) disable iff (!nrst_in)
        enter_meas && act_en |=> ref_pend_q;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not armed");
endmodule : amd_ctrl
`default_nettype wire

// [amd_adc_model.sv]
`default_nettype none
module amd_adc_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic convert_in,
    input wire amd_pkg::amd_sample_t value_in,
    output var amd_pkg::amd_sample_t sample_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import amd_pkg::*;
    // ************************************************************
    // Converter front end
    // ************************************************************
    amd_sample_t hold_q;
    // Held for one cycle after the request, then the lines toggle every cycle,
    // so a late capture sees the complement of the sample or the sample again
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_q <= '0;
        end else if (convert_in) begin
            hold_q <= value_in;
        end else begin
            hold_q <= ~hold_q;
        end
    end
    always_comb begin
        sample_out = convert_in ? value_in : hold_q;
    end
endmodule // amd_adc_model
`default_nettype wire

// [amd_ctrl_tb.sv]
`default_nettype none
module amd_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amd_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} amd_row_t;
    // Shortened divider keeps the run short; 400 Hz becomes DIV_400 >> RATE_SHIFT
    localparam int RATE_SHIFT = 10;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    amd_sample_t adc_sample;
    amd_sample_t model_value = '0;
    logic adc_convert;
    amd_afe_cfg_t afe_cfg;
    logic afe_power, act_irq, inact_irq, awake;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int last_conv = 0;
    int period = 0;
    int conv_cnt = 0;
    logic [31:0] rd;
    amd_row_t rows [8] = '{
        '{ADDR_CTRL, 32'hfffc02d8, 32'h000002d8}, '{ADDR_CTRL, 32'h00000104, 32'h00000104},
        '{ADDR_CTRL, 32'h00000003, 32'h00000003}, '{ADDR_ACT_THR, 32'hfffff123, 32'h00000123},
        '{ADDR_ACT_TIME, 32'habcd1234, 32'h00001234},
        '{ADDR_INACT_THR, 32'h00001fff, 32'h00000fff},
        '{ADDR_INACT_TIME, 32'h0001ffff, 32'h0000ffff}, '{8'h1c, 32'h00000055, UNMAPPED_DATA}};

    always #5 clk_in = ~clk_in;

    amd_ctrl #(.RATE_SHIFT(RATE_SHIFT)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .adc_sample_in(adc_sample), .adc_convert_out(adc_convert), .afe_cfg_out(afe_cfg),
        .afe_power_out(afe_power), .act_irq_out(act_irq), .inact_irq_out(inact_irq),
        .awake_out(awake));

    amd_adc_model adc (.clk_in(clk_in), .nrst_in(nrst_in), .convert_in(adc_convert),
        .value_in(model_value), .sample_out(adc_sample));

    // ************************************************************
    // Conversion pacing monitor
    // ************************************************************
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (adc_convert === 1'b1) begin
            period <= cyc - last_conv;
            last_conv <= cyc;
            conv_cnt <= conv_cnt + 1;
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until waitrequest is sampled low; only then released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        rd = avs_readdata_out;
        chk("bus answer", 32'h1, 32'(n < 100));
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    // Bound covers one wake-up period with the shortened divider
    task automatic wait_conv();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (adc_convert !== 1'b1 && n < 20000);
        chk("convert pulse", 32'h1, 32'(n < 20000));
        repeat (6) @(posedge clk_in);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        final_report();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("afe_cfg reset", 32'h0, 32'(afe_cfg));
        chk("afe_power reset", 32'h0, 32'(afe_power));
        chk("awake reset", 32'h0, 32'(awake));
        xfer(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].w);
            xfer(1'b0, rows[i].a, 32'h0);
            chk("readback", rows[i].r, rd);
            if (rows[i].a == ADDR_CTRL) begin
                chk("afe_cfg", {rows[i].w[9:8], rows[i].w[3:2], rows[i].w[7]}, 32'(afe_cfg));
                chk("afe_power standby", 32'h0, 32'(afe_power));
            end
        end
        repeat (1000) @(posedge clk_in);
        chk("standby conversions", 32'h0, 32'(conv_cnt));
        $display("test table done");
        // One negative axis above threshold, activity time of one sample
        xfer(1'b1, ADDR_ACT_THR, 32'h00000064);
        xfer(1'b1, ADDR_ACT_TIME, 32'h0);
        model_value <= '{x: -12'sd200, y: 12'sd0, z: 12'sd0};
        xfer(1'b1, ADDR_CTRL, 32'h00008452);
        repeat (3) @(posedge clk_in);
        chk("afe_power measure", 32'h1, 32'(afe_power));
        wait_conv();
        chk("act irq", 32'h1, 32'(act_irq));
        chk("awake", 32'h1, 32'(awake));
        xfer(1'b1, ADDR_CTRL, 32'h00008450);
        repeat (3) @(posedge clk_in);
        chk("act irq kept", 32'h1, 32'(act_irq));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h5, rd & 32'h7);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status cleared", 32'h4, rd & 32'h7);
        chk("act irq cleared", 32'h0, 32'(act_irq));
        rd = 32'(conv_cnt);
        repeat (300) @(posedge clk_in);
        chk("no standby sample", rd, 32'(conv_cnt));
        $display("test absolute activity done");
        // Steady 300 on z is no motion once the reference holds it
        model_value <= '{x: 12'sd0, y: 12'sd0, z: 12'sd300};
        xfer(1'b1, ADDR_CTRL, 32'h00009452);
        wait_conv();
        xfer(1'b0, ADDR_STATUS, 32'h0);
        wait_conv();
        chk("sample period", 32'(DIV_400 >> RATE_SHIFT), 32'(period));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("no act at reference", 32'h0, rd & 32'h1);
        model_value <= '{x: 12'sd0, y: 12'sd0, z: 12'sd450};
        wait_conv();
        chk("act irq referenced", 32'h1, 32'(act_irq));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("act referenced", 32'h1, rd & 32'h1);
        $display("test referenced activity done");
        // All axes inside the quiet band; inactivity time of two samples
        xfer(1'b1, ADDR_INACT_THR, 32'h00000064);
        xfer(1'b1, ADDR_INACT_TIME, 32'h00000002);
        model_value <= '{x: 12'sd10, y: -12'sd20, z: 12'sd30};
        xfer(1'b1, ADDR_CTRL, 32'h00010852);
        wait_conv();
        chk("inact irq early", 32'h0, 32'(inact_irq));
        wait_conv();
        chk("inact irq", 32'h1, 32'(inact_irq));
        chk("asleep", 32'h0, 32'(awake));
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status inact", 32'h2, rd & 32'h7);
        $display("test inactivity done");
        // Wake-up mode judges one sample although the activity time asks for three
        xfer(1'b1, ADDR_ACT_TIME, 32'h00000003);
        model_value <= '{x: -12'sd200, y: 12'sd0, z: 12'sd0};
        xfer(1'b1, ADDR_CTRL, 32'h00008401);
        wait_conv();
        chk("act irq wake-up", 32'h1, 32'(act_irq));
        chk("awake wake-up", 32'h1, 32'(awake));
        $display("test wake-up done");
        final_report();
    end
endmodule // amd_ctrl_tb
`default_nettype wire
